// ---- core/cot_pkg.sv ----
// Package with register map, field positions and reset values of the compare output block
package cot_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PWM_CTRL = 8'hc1;
  localparam logic [7:0] ADDR_TRAP_CTRL = 8'hcf;
  localparam logic [7:0] ADDR_PER_LO = 8'hd2;
  localparam logic [7:0] ADDR_PER_HI = 8'hd3;
  localparam logic [7:0] ADDR_CMP_LO = 8'hd4;
  localparam logic [7:0] ADDR_CMP_HI = 8'hd5;
  localparam logic [7:0] ADDR_INIT_LVL = 8'he2;

  // Reset values
  localparam logic [7:0] RST_PWM_CTRL = 8'h10;
  localparam logic [7:0] RST_TRAP_CTRL = 8'h00;
  localparam logic [7:0] RST_INIT_LVL = 8'hff;
  localparam logic [7:0] RST_SHADOW = 8'h00;

  // pwm_timer_control fields
  localparam int PC_PERIOD_FLAG = 7;
  localparam int PC_OUT_EN = 6;
  localparam int PC_SHADOW_EN = 5;
  localparam int PC_CLEAR = 4;
  localparam int PC_RUN = 3;
  localparam int PC_CLKSEL_HI = 2;

  // trap_control fields
  localparam int TC_GLOBAL_EN = 7;
  localparam int TC_FLAG = 6;
  localparam int TC_OUT_EN_HI = 5;

  // output_initial_levels fields
  localparam int IL_AUX = 7;
  localparam int IL_PHASE_INV = 6;
  localparam int IL_OUT_HI = 5;

  // Compare output count and counter width
  localparam int NUM_OUTS = 6;
  localparam int CNT_WIDTH = 10;

endpackage

// ---- core/cot_pwm_trap.sv ----
// Compare output trap control and single channel 10-bit PWM timer
//
// Functional notes
// - Aux output shows its initial level before first start and when output disabled.
// - Inversion bit inverts the PWM waveform routed to phase outputs.
// - Even level bits drive channel outputs, odd bits drive phase outputs.
// - Compare timer 1 idle: compare-enabled outputs drive push-pull their initial level.
// - Timer running and trap enable set: output forced to initial level in trap.
// - Initial and trap levels only act on outputs in compare mode.
// - Global trap enable gates the trap input; cleared after reset.
// - Enabled trap input low sets the trap flag; only software clears it.
// - Per output trap enable: 0 keeps compare signal, 1 forces initial level.
// - Writing trap flag as one with the enables raises a software trap.
// - PWM counter is 10-bit, counts from zero to period then wraps.
// - Aux waveform toggles on compare match and again at wrap to zero.
// - Aux output drives high after reset from the initial level reset value.
// - Clearing output enable while running shows initial level on aux only; setting restores waveform.
// - PWM waveform can be routed to phase or channel outputs.
// - Period and compare byte writes land in shadow latches only.
// - Shadow enable copies latches to active values at next zero count, then clears.
// - Period and compare byte reads return shadow latch contents masked to the counter width.
// - Control at c1, period bytes at d2/d3, compare bytes at d4/d5.
// - Stop-and-reset setting halts and clears counter, aux shows initial level.
// - Period match sets the period flag; software clears it.
`timescale 1ns/1ps

module cot_pwm_trap #(
  parameter int CNT_W = cot_pkg::CNT_WIDTH
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic trap_input_n_i,
  input wire logic cmp_timer1_run_i,
  input wire logic [5:0] compare_mode_en_i,
  input wire logic [5:0] compare_sig_i,
  input wire logic [5:0] pwm_route_i,
  output logic [2:0] channel_compare_output_o,
  output logic [2:0] phase_output_o,
  output logic [5:0] compare_oe_o,
  output logic aux_pwm_output_o,
  output logic trap_flag_o,
  output logic pwm_period_flag_o
);

  // Read masking and the shadow byte split only serve widths from 2 to 16
  if (CNT_W < 2 || CNT_W > 16)
  begin : g_bad_width
    $error("CNT_W must lie between 2 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  logic wr_ctrl;
  logic wr_trap;
  logic wr_per_lo;
  logic wr_per_hi;
  logic wr_cmp_lo;
  logic wr_cmp_hi;
  logic wr_init;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_PWM_CTRL);
  assign wr_trap = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_TRAP_CTRL);
  assign wr_per_lo = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_PER_LO);
  assign wr_per_hi = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_PER_HI);
  assign wr_cmp_lo = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_CMP_LO);
  assign wr_cmp_hi = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_CMP_HI);
  assign wr_init = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_INIT_LVL);

  ////////////////////////////////////////////////////////////////////////////
  // Plain storage registers

  logic [7:0] init_lvl_q;
  logic [5:0] trap_out_en_q;
  logic trap_glob_en_q;
  logic out_en_q;
  logic run_q;
  logic clr_q;
  logic [2:0] clk_sel_q;
  logic [15:0] per_shadow_q;
  logic [15:0] cmp_shadow_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      init_lvl_q <= cot_pkg::RST_INIT_LVL;
    end
    else if (wr_init)
    begin
      init_lvl_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trap_glob_en_q <= cot_pkg::RST_TRAP_CTRL[cot_pkg::TC_GLOBAL_EN];
      trap_out_en_q <= cot_pkg::RST_TRAP_CTRL[cot_pkg::TC_OUT_EN_HI:0];
    end
    else if (wr_trap)
    begin
      trap_glob_en_q <= reg_wdata_i[cot_pkg::TC_GLOBAL_EN];
      trap_out_en_q <= reg_wdata_i[cot_pkg::TC_OUT_EN_HI:0];
    end
  end

  // Clock select is held for software only; the counter steps every clock
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_en_q <= cot_pkg::RST_PWM_CTRL[cot_pkg::PC_OUT_EN];
      run_q <= cot_pkg::RST_PWM_CTRL[cot_pkg::PC_RUN];
      clr_q <= cot_pkg::RST_PWM_CTRL[cot_pkg::PC_CLEAR];
      clk_sel_q <= cot_pkg::RST_PWM_CTRL[cot_pkg::PC_CLKSEL_HI:0];
    end
    else if (wr_ctrl)
    begin
      out_en_q <= reg_wdata_i[cot_pkg::PC_OUT_EN];
      run_q <= reg_wdata_i[cot_pkg::PC_RUN];
      clr_q <= reg_wdata_i[cot_pkg::PC_CLEAR];
      clk_sel_q <= reg_wdata_i[cot_pkg::PC_CLKSEL_HI:0];
    end
  end

  // Shadow latches hold all 16 bits; reads and transfers use only the low CNT_W bits
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      per_shadow_q <= {cot_pkg::RST_SHADOW, cot_pkg::RST_SHADOW};
      cmp_shadow_q <= {cot_pkg::RST_SHADOW, cot_pkg::RST_SHADOW};
    end
    else
    begin
      if (wr_per_lo)
      begin
        per_shadow_q[7:0] <= reg_wdata_i;
      end
      if (wr_per_hi)
      begin
        per_shadow_q[15:8] <= reg_wdata_i;
      end
      if (wr_cmp_lo)
      begin
        cmp_shadow_q[7:0] <= reg_wdata_i;
      end
      if (wr_cmp_hi)
      begin
        cmp_shadow_q[15:8] <= reg_wdata_i;
      end
    end
  end

  logic [15:0] width_mask;
  assign width_mask = 16'hffff >> (16 - CNT_W);

  ////////////////////////////////////////////////////////////////////////////
  // PWM counter with shadow transfer

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] per_act_q;
  logic [CNT_W-1:0] cmp_act_q;
  logic shadow_en_q;
  logic halted_clear;
  logic period_hit;
  logic xfer;

  assign halted_clear = clr_q && !run_q;
  assign period_hit = run_q && (cnt_q == per_act_q);

  always_comb
  begin
    cnt_d = cnt_q;
    if (halted_clear)
    begin
      cnt_d = '0;
    end
    else if (period_hit)
    begin
      cnt_d = '0;
    end
    else if (run_q)
    begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // Transfer lands with the counter at zero, also while it waits cleared
  assign xfer = shadow_en_q && (cnt_d == '0);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      per_act_q <= '0;
      cmp_act_q <= '0;
    end
    else if (xfer)
    begin
      per_act_q <= per_shadow_q[CNT_W-1:0];
      cmp_act_q <= cmp_shadow_q[CNT_W-1:0];
    end
  end

  // A software set in the transfer cycle wins over the hardware clear
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shadow_en_q <= cot_pkg::RST_PWM_CTRL[cot_pkg::PC_SHADOW_EN];
    end
    else if (wr_ctrl && reg_wdata_i[cot_pkg::PC_SHADOW_EN])
    begin
      shadow_en_q <= 1'b1;
    end
    else if (xfer)
    begin
      shadow_en_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      shadow_en_q <= 1'b0;
    end
  end

  // Period flag: hardware set wins over a software clear
  logic per_flag_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      per_flag_q <= cot_pkg::RST_PWM_CTRL[cot_pkg::PC_PERIOD_FLAG];
    end
    else if (period_hit)
    begin
      per_flag_q <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      per_flag_q <= reg_wdata_i[cot_pkg::PC_PERIOD_FLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM waveform and aux output

  logic wave_q;
  logic started_q;
  logic tog_cmp;
  logic tog_wrap;
  logic aux_d;

  assign tog_cmp = run_q && (cnt_q == cmp_act_q);
  assign tog_wrap = period_hit;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wave_q <= cot_pkg::RST_INIT_LVL[cot_pkg::IL_AUX];
    end
    else if (halted_clear || !started_q)
    begin
      wave_q <= init_lvl_q[cot_pkg::IL_AUX];
    end
    else
    begin
      // Both events in one cycle cancel, leaving a zero-width pulse out
      wave_q <= wave_q ^ tog_cmp ^ tog_wrap;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      started_q <= 1'b0;
    end
    else if (halted_clear)
    begin
      started_q <= 1'b0;
    end
    else if (run_q)
    begin
      started_q <= 1'b1;
    end
  end

  always_comb
  begin
    aux_d = wave_q;
    if (!started_q || halted_clear || !out_en_q)
    begin
      aux_d = init_lvl_q[cot_pkg::IL_AUX];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aux_pwm_output_o <= cot_pkg::RST_INIT_LVL[cot_pkg::IL_AUX];
    end
    else
    begin
      aux_pwm_output_o <= aux_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trap input synchroniser and trap flag

  logic [2:0] trap_sync_q;
  logic trap_lvl_n_q;
  logic trap_flag_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trap_sync_q <= 3'h7;
    end
    else
    begin
      trap_sync_q <= {trap_sync_q[1:0], trap_input_n_i};
    end
  end

  // Level only moves once the last two stages agree, filtering one-clock glitches
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trap_lvl_n_q <= 1'b1;
    end
    else if (trap_sync_q[1] == trap_sync_q[2])
    begin
      trap_lvl_n_q <= trap_sync_q[2];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trap_flag_q <= cot_pkg::RST_TRAP_CTRL[cot_pkg::TC_FLAG];
    end
    else if (trap_glob_en_q && !trap_lvl_n_q)
    begin
      trap_flag_q <= 1'b1;
    end
    else if (wr_trap)
    begin
      trap_flag_q <= reg_wdata_i[cot_pkg::TC_FLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare outputs

  logic [5:0] out_d;
  logic [5:0] out_q;
  logic [5:0] oe_q;

  genvar gi;
  generate
    for (gi = 0; gi < cot_pkg::NUM_OUTS; gi++)
    begin : g_out
      logic norm;
      // Odd positions are phase outputs; only they see the inversion
      if (gi % 2 == 1)
      begin : g_phase
        assign norm = pwm_route_i[gi] ?
          (wave_q ^ init_lvl_q[cot_pkg::IL_PHASE_INV]) : compare_sig_i[gi];
      end
      else
      begin : g_chan
        assign norm = pwm_route_i[gi] ? wave_q : compare_sig_i[gi];
      end
      always_comb
      begin
        out_d[gi] = norm;
        if (!compare_mode_en_i[gi])
        begin
          out_d[gi] = 1'b0;
        end
        else if (!cmp_timer1_run_i)
        begin
          out_d[gi] = init_lvl_q[gi];
        end
        else if (trap_flag_q && trap_out_en_q[gi])
        begin
          out_d[gi] = init_lvl_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_q <= 6'h00;
      oe_q <= 6'h00;
    end
    else
    begin
      out_q <= out_d;
      oe_q <= compare_mode_en_i;
    end
  end

  assign channel_compare_output_o = {out_q[4], out_q[2], out_q[0]};
  assign phase_output_o = {out_q[5], out_q[3], out_q[1]};
  assign compare_oe_o = oe_q;
  assign trap_flag_o = trap_flag_q;
  assign pwm_period_flag_o = per_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  logic [7:0] rd_d;

  always_comb
  begin
    rd_d = 8'h00;
    if (reg_addr_i == cot_pkg::ADDR_PWM_CTRL)
    begin
      rd_d = {per_flag_q, out_en_q, shadow_en_q, clr_q, run_q, clk_sel_q};
    end
    else if (reg_addr_i == cot_pkg::ADDR_TRAP_CTRL)
    begin
      rd_d = {trap_glob_en_q, trap_flag_q, trap_out_en_q};
    end
    else if (reg_addr_i == cot_pkg::ADDR_PER_LO)
    begin
      rd_d = per_shadow_q[7:0] & width_mask[7:0];
    end
    else if (reg_addr_i == cot_pkg::ADDR_PER_HI)
    begin
      rd_d = per_shadow_q[15:8] & width_mask[15:8];
    end
    else if (reg_addr_i == cot_pkg::ADDR_CMP_LO)
    begin
      rd_d = cmp_shadow_q[7:0] & width_mask[7:0];
    end
    else if (reg_addr_i == cot_pkg::ADDR_CMP_HI)
    begin
      rd_d = cmp_shadow_q[15:8] & width_mask[15:8];
    end
    else if (reg_addr_i == cot_pkg::ADDR_INIT_LVL)
    begin
      rd_d = init_lvl_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= rd_d;
    end
    else
    begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

// ---- verification/cot_pwm_trap_chk.sv ----
// Assertion checker for the compare output trap and PWM timer block
`timescale 1ns/1ps

module cot_pwm_trap_chk #(
  parameter int CNT_W = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic trap_input_n_i,
  input wire logic cmp_timer1_run_i,
  input wire logic [5:0] compare_mode_en_i,
  input wire logic [2:0] channel_compare_output_o,
  input wire logic [2:0] phase_output_o,
  input wire logic [5:0] compare_oe_o,
  input wire logic aux_pwm_output_o,
  input wire logic trap_flag_o,
  input wire logic pwm_period_flag_o
);
  logic [7:0] init_q;
  logic [7:0] ctl_q;
  logic [7:0] tc_q;
  logic [5:0] outs;
  logic wr_tc;
  logic wr_pc;

  assign outs = {phase_output_o[2], channel_compare_output_o[2], phase_output_o[1],
    channel_compare_output_o[1], phase_output_o[0], channel_compare_output_o[0]};
  assign wr_tc = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_TRAP_CTRL);
  assign wr_pc = reg_wr_i && (reg_addr_i == cot_pkg::ADDR_PWM_CTRL);

  // Software copies; the flag bits that hardware sets are never relied on
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      init_q <= cot_pkg::RST_INIT_LVL;
      ctl_q <= cot_pkg::RST_PWM_CTRL;
      tc_q <= cot_pkg::RST_TRAP_CTRL;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == cot_pkg::ADDR_INIT_LVL)
        init_q <= reg_wdata_i;
      if (wr_pc)
        ctl_q <= reg_wdata_i;
      if (wr_tc)
        tc_q <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  oe_copy_a: assert property ($past(rst_n_i) |-> compare_oe_o == $past(compare_mode_en_i))
    else $error("drive enable does not follow compare mode");
  rdata_idle_a: assert property ($past(rst_n_i) && !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data present without a read");
  non_compare_a: assert property ($past(rst_n_i) |-> (outs & ~$past(compare_mode_en_i)) == 6'h00)
    else $error("output driven while not in compare mode");
  idle_level_a: assert property ($past(rst_n_i) && !$past(cmp_timer1_run_i)
    |-> ((outs ^ $past(init_q[5:0])) & $past(compare_mode_en_i)) == 6'h00)
    else $error("idle output differs from its initial level");
  trap_force_a: assert property ($past(rst_n_i) && $past(trap_flag_o && cmp_timer1_run_i)
    |-> ((outs ^ $past(init_q[5:0])) & $past(tc_q[5:0] & compare_mode_en_i)) == 6'h00)
    else $error("trapped output not at its initial level");
  trap_hold_a: assert property ($past(rst_n_i) && $past(trap_flag_o) && !$past(wr_tc) |-> trap_flag_o)
    else $error("trap flag cleared without software");
  trap_gate_a: assert property ($past(rst_n_i) && $rose(trap_flag_o) |-> $past(wr_tc) || $past(tc_q[7]))
    else $error("trap flag set while trap input disabled");
  trap_detect_a: assert property ((tc_q[7] && !trap_input_n_i)[*6] |-> ##1 trap_flag_o)
    else $error("trap input low but flag not set");
  period_hold_a: assert property ($past(rst_n_i) && $past(pwm_period_flag_o) && !$past(wr_pc)
    |-> pwm_period_flag_o)
    else $error("period flag cleared without software");
  aux_init_a: assert property ($past(rst_n_i) && $past((ctl_q[4] && !ctl_q[3]) || !ctl_q[6])
    |-> aux_pwm_output_o == $past(init_q[7]))
    else $error("aux output not at its initial level");
endmodule

bind cot_pwm_trap cot_pwm_trap_chk #(.CNT_W(CNT_W)) u_cot_pwm_trap_chk (
  .core_clk_i,
  .rst_n_i,
  .reg_addr_i,
  .reg_wdata_i,
  .reg_wr_i,
  .reg_rd_i,
  .reg_rdata_o,
  .trap_input_n_i,
  .cmp_timer1_run_i,
  .compare_mode_en_i,
  .channel_compare_output_o,
  .phase_output_o,
  .compare_oe_o,
  .aux_pwm_output_o,
  .trap_flag_o,
  .pwm_period_flag_o
);

// ---- verification/cot_pwm_trap_bench.sv ----
// Self-checking random testbench for the compare output trap and PWM timer block
`timescale 1ns/1ps

module cot_pwm_trap_bench;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic trap_input_n_i = 1'b1;
  logic cmp_timer1_run_i = 1'b0;
  logic [5:0] compare_mode_en_i = 6'h00;
  logic [5:0] compare_sig_i = 6'h00;
  logic [5:0] pwm_route_i = 6'h00;
  logic [1:0] duty_sel = 2'h0;
  logic duty_sig;
  logic [7:0] reg_rdata_o;
  logic [2:0] channel_compare_output_o;
  logic [2:0] phase_output_o;
  logic [5:0] compare_oe_o;
  logic aux_pwm_output_o;
  logic trap_flag_o;
  logic pwm_period_flag_o;
  int num_errors = 0;
  int check_count = 0;

  always #5 core_clk_i = ~core_clk_i;

  // Duty counting picks the aux pin or the lowest channel or phase pin
  assign duty_sig = (duty_sel == 2'h0) ? aux_pwm_output_o :
    ((duty_sel == 2'h1) ? channel_compare_output_o[0] : phase_output_o[0]);

  cot_pwm_trap u_cot_pwm_trap (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .trap_input_n_i(trap_input_n_i),
    .cmp_timer1_run_i(cmp_timer1_run_i),
    .compare_mode_en_i(compare_mode_en_i),
    .compare_sig_i(compare_sig_i),
    .pwm_route_i(pwm_route_i),
    .channel_compare_output_o(channel_compare_output_o),
    .phase_output_o(phase_output_o),
    .compare_oe_o(compare_oe_o),
    .aux_pwm_output_o(aux_pwm_output_o),
    .trap_flag_o(trap_flag_o),
    .pwm_period_flag_o(pwm_period_flag_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_val(16'(reg_rdata_o), 16'(e));
    @(posedge core_clk_i);
  endtask

  function automatic logic [5:0] exp_outs(input logic [5:0] lvl, input logic [5:0] ten,
    input logic trapped);
    logic [5:0] v;
    v = cmp_timer1_run_i ? compare_sig_i : lvl;
    if (trapped && cmp_timer1_run_i)
      v = (v & ~ten) | (lvl & ten);
    return v & compare_mode_en_i;
  endfunction

  task automatic chk_outs(input logic [5:0] lvl, input logic [5:0] ten, input logic trapped);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk_val(16'({phase_output_o[2], channel_compare_output_o[2], phase_output_o[1],
      channel_compare_output_o[1], phase_output_o[0], channel_compare_output_o[0]}),
      16'(exp_outs(lvl, ten, trapped)));
    chk_val(16'(compare_oe_o), 16'(compare_mode_en_i));
    @(posedge core_clk_i);
  endtask

  // Whole periods are counted, so the result does not depend on the start phase
  task automatic duty(input int n, input int e);
    int hi;
    hi = 0;
    repeat (n)
    begin
      @(posedge core_clk_i);
      #1;
      hi += (duty_sig === 1'b1);
    end
    chk_val(16'(hi), 16'(e));
    @(posedge core_clk_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] lvl;
    logic [7:0] ten;
    logic [7:0] v;
    int p;
    int c;
    int po;
    int co;
    void'($urandom(32'hf727));
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk_val(16'(aux_pwm_output_o), 16'h1);
    @(posedge core_clk_i);
    rd_chk(cot_pkg::ADDR_PWM_CTRL, 8'h10);
    rd_chk(cot_pkg::ADDR_TRAP_CTRL, 8'h00);
    rd_chk(cot_pkg::ADDR_INIT_LVL, 8'hff);
    rd_chk(8'hd0, 8'h00);
    $display("test reset finished");
    for (int a = 8'hd2; a <= 8'hd5; a++)
    begin
      v = 8'($urandom);
      wr(8'(a), v);
      rd_chk(8'(a), a[0] ? (v & 8'h03) : v);
    end
    $display("test shadow finished");
    wr(cot_pkg::ADDR_PER_HI, 8'h00);
    wr(cot_pkg::ADDR_CMP_HI, 8'h00);
    wr(cot_pkg::ADDR_INIT_LVL, 8'h3f);
    po = 0;
    co = 0;
    for (int k = 0; k < 3; k++)
    begin
      p = 4 + $urandom_range(16);
      c = 1 + $urandom_range(p - 2);
      wr(cot_pkg::ADDR_PER_LO, 8'(p));
      wr(cot_pkg::ADDR_CMP_LO, 8'(c));
      if (k == 0)
      begin
        wr(cot_pkg::ADDR_PWM_CTRL, 8'h70);
        wr(cot_pkg::ADDR_PWM_CTRL, 8'h48);
      end
      else
      begin
        duty(3 * (po + 1), 3 * (po - co));
        wr(cot_pkg::ADDR_PWM_CTRL, 8'h68);
      end
      repeat (30) @(posedge core_clk_i);
      duty(3 * (p + 1), 3 * (p - c));
      chk_val(16'(pwm_period_flag_o), 16'h1);
      rd_chk(cot_pkg::ADDR_PWM_CTRL, 8'hc8);
      po = p;
      co = c;
    end
    wr(cot_pkg::ADDR_PWM_CTRL, 8'h08);
    duty(3 * (po + 1), 0);
    wr(cot_pkg::ADDR_INIT_LVL, 8'hbf);
    duty(10, 10);
    wr(cot_pkg::ADDR_PWM_CTRL, 8'h48);
    duty(3 * (po + 1), 3 * (po - co));
    $display("test pwm finished");
    // Waveform routed to every pin; phase pins see the inversion, channel pins do not
    compare_mode_en_i <= 6'h3f;
    cmp_timer1_run_i <= 1'b1;
    pwm_route_i <= 6'h3f;
    wr(cot_pkg::ADDR_INIT_LVL, 8'h40);
    duty_sel = 2'h1;
    duty(3 * (po + 1), 3 * (po - co));
    duty_sel = 2'h2;
    duty(3 * (po + 1), 3 * (co + 1));
    pwm_route_i <= 6'h00;
    duty_sel = 2'h0;
    $display("test route finished");
    for (int k = 0; k < 3; k++)
    begin
      lvl = 8'($urandom);
      ten = 8'($urandom);
      wr(cot_pkg::ADDR_TRAP_CTRL, 8'h00);
      wr(cot_pkg::ADDR_INIT_LVL, lvl);
      cmp_timer1_run_i <= 1'b0;
      compare_mode_en_i <= 6'($urandom);
      compare_sig_i <= 6'($urandom);
      chk_outs(lvl[5:0], ten[5:0], 1'b0);
      cmp_timer1_run_i <= 1'b1;
      chk_outs(lvl[5:0], ten[5:0], 1'b0);
      trap_input_n_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      chk_val(16'(trap_flag_o), 16'h0);
      wr(cot_pkg::ADDR_TRAP_CTRL, {2'b10, ten[5:0]});
      repeat (8) @(posedge core_clk_i);
      chk_val(16'(trap_flag_o), 16'h1);
      chk_outs(lvl[5:0], ten[5:0], 1'b1);
      trap_input_n_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      chk_val(16'(trap_flag_o), 16'h1);
      wr(cot_pkg::ADDR_TRAP_CTRL, {2'b10, ten[5:0]});
      chk_val(16'(trap_flag_o), 16'h0);
      wr(cot_pkg::ADDR_TRAP_CTRL, {2'b01, ten[5:0]});
      chk_val(16'(trap_flag_o), 16'h1);
      chk_outs(lvl[5:0], ten[5:0], 1'b1);
    end
    $display("test trap finished");
    tally_and_finish();
  end
endmodule
